/* core/wdc_pkg.sv */
package wdc_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [9:0]  CTRL_IDX       = 10'h0aa;
   localparam logic [9:0]  UNLOCK_IDX     = 10'h0c7;
   localparam logic [9:0]  IRQ_STAT_IDX   = 10'h0f0;
   localparam logic [9:0]  IRQ_EN_IDX     = 10'h0f1;
   localparam logic [9:0]  IRQ_CLR_IDX    = 10'h0f2;
   localparam logic [9:0]  COUNT_IDX      = 10'h0f3;
   localparam logic [11:0] CTRL_ADDR      = {CTRL_IDX, 2'b00};
   localparam logic [11:0] UNLOCK_ADDR    = {UNLOCK_IDX, 2'b00};
   localparam logic [11:0] IRQ_STAT_ADDR  = {IRQ_STAT_IDX, 2'b00};
   localparam logic [11:0] IRQ_EN_ADDR    = {IRQ_EN_IDX, 2'b00};
   localparam logic [11:0] IRQ_CLR_ADDR   = {IRQ_CLR_IDX, 2'b00};
   localparam logic [11:0] COUNT_ADDR     = {COUNT_IDX, 2'b00};

   // Field positions of the watchdog control register.
   localparam int          RUN_BIT        = 7;
   localparam int          CLR_BIT        = 6;
   localparam int          TOF_BIT        = 5;
   localparam int          LPR_BIT        = 4;
   localparam int          RCF_BIT        = 3;
   localparam int          PS_MSB         = 2;
   localparam int          PS_LSB         = 0;

   // Reset values.
   localparam logic [2:0]  PS_POR         = 3'h7;
   localparam logic [3:0]  NV_GP_TIMER    = 4'hf;
   localparam logic [1:0]  IRQ_EN_RST     = 2'h0;

   // Interrupt status layout.
   localparam int          IRQ_TIMEOUT    = 0;
   localparam int          IRQ_CLR_DONE   = 1;
   localparam int          IRQ_W          = 2;

   // Timed-access unlock keys and the length of the open window in cycles.
   localparam logic [7:0]  UNLOCK_KEY1    = 8'haa;
   localparam logic [7:0]  UNLOCK_KEY2    = 8'h55;
   localparam logic [3:0]  UNLOCK_WIN_CYC = 4'h8;

   // Watchdog counter width.
   localparam int          COUNT_W        = 6;

   typedef enum logic [2:0] {
      UNL_LOCKED = 3'b001,
      UNL_ARMED  = 3'b010,
      UNL_OPEN   = 3'b100
   } wdc_unlock_e;

endpackage : wdc_pkg

/* core/wdc_prescaler.sv */
module wdc_prescaler (
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset,
   input  wire logic       i_clk_en,
   input  wire logic       i_enable,
   input  wire logic       i_restart,
   input  wire logic [2:0] i_select,
   output logic            o_tick
);

   logic [7:0] div_last;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;

   // Division ratios rise monotonically from 1 to 256 over the eight codes.
   always_comb begin
      case (i_select)
         3'h0:    div_last = 8'h00;
         3'h1:    div_last = 8'h03;
         3'h2:    div_last = 8'h07;
         3'h3:    div_last = 8'h0f;
         3'h4:    div_last = 8'h1f;
         3'h5:    div_last = 8'h3f;
         3'h6:    div_last = 8'h7f;
         default: div_last = 8'hff;
      endcase
   end

   // A tick marks the last input cycle of each divided period.
   assign o_tick = i_enable && !i_restart && (cnt_q >= div_last);

   // The divider holds while disabled and restarts on a counter clear.
   always_comb begin
      cnt_d = cnt_q;
      if (i_restart || o_tick) begin
         cnt_d = 8'h00;
      end else if (i_enable) begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   // Divider register.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         cnt_q <= 8'h00;
      end else if (i_clk_en) begin
         cnt_q <= cnt_d;
      end
   end

endmodule : wdc_prescaler

/* core/wdc_watchdog_control.sv */
// Overview of operation
// - With enable field all ones, run bit starts or stops the general-purpose counter.
// - Writing one to clear bit zeroes the counter; writing zero does nothing.
// - Clear bit reads one until the requested counter clear has completed.
// - Counter overflow sets the timeout flag; software, power-on, watchdog and other resets clear it.
// - In timer use, low-power run bit keeps counter running in idle or power-down.
// - A watchdog timeout reset sets the reset cause flag; software may clear it.
// - Reset cause flag: cleared by power-on, set by watchdog reset, else kept.
// - Three-bit prescale field selects watchdog clock division from 1 to 256.
// - Power-on sets prescale bits to ones; other resets keep them.
// - Control register writes are ignored unless the timed-access unlock preceded them.
//
// The APB interface to the registers was chosen for this implementation.
module wdc_watchdog_control (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_clk_en,
   input  wire logic        i_wdt_reset,
   input  wire logic        i_other_reset,
   input  wire logic        i_lowpower,
   input  wire logic [3:0]  i_nv_enable_field,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic             o_irq,
   output logic             o_wd_reset_req
);

   // Control register fields.
   logic                        wd_run_q;
   logic                        wd_run_d;
   logic                        wd_count_clear_q;
   logic                        wd_count_clear_d;
   logic                        wd_timeout_flag_q;
   logic                        wd_timeout_flag_d;
   logic                        wd_lowpower_run_q;
   logic                        wd_lowpower_run_d;
   logic                        wd_reset_cause_flag_q;
   logic                        wd_reset_cause_flag_d;
   logic [2:0]                  wd_prescale_select_q;
   logic [2:0]                  wd_prescale_select_d;

   // Counter, unlock sequencer, interrupt and bus state.
   logic [wdc_pkg::COUNT_W-1:0] count_q;
   logic [wdc_pkg::COUNT_W-1:0] count_d;
   wdc_pkg::wdc_unlock_e        unl_q;
   wdc_pkg::wdc_unlock_e        unl_d;
   logic [3:0]                  win_q;
   logic [3:0]                  win_d;
   logic [wdc_pkg::IRQ_W-1:0]   irq_stat_q;
   logic [wdc_pkg::IRQ_W-1:0]   irq_stat_d;
   logic [wdc_pkg::IRQ_W-1:0]   irq_en_q;
   logic [wdc_pkg::IRQ_W-1:0]   irq_en_d;
   logic [31:0]                 prdata_q;
   logic [31:0]                 prdata_d;
   logic                        rst_req_q;
   logic                        rst_req_d;

   logic                        any_reset;
   logic                        gp_mode;
   logic                        count_run;
   logic                        tick;
   logic                        overflow;
   logic                        addr_ok;
   logic                        wr_acc;
   logic                        ctrl_wr;
   logic [7:0]                  ctrl_rd;

   // A watchdog or other reset counts as a non-power-on reset source.
   assign any_reset = i_wdt_reset || i_other_reset;

   // General-purpose timer use only when every enable bit is one.
   assign gp_mode = (i_nv_enable_field == wdc_pkg::NV_GP_TIMER);

   // In watchdog use the counter always runs; in timer use the run bit gates it.
   assign count_run = gp_mode ? (wd_run_q && (!i_lowpower || wd_lowpower_run_q))
                              : 1'b1;

   // Overflow when the counter wraps on a prescaled tick.
   assign overflow = tick && (&count_q) && !wd_count_clear_q;

   // Bus decode; the slave never inserts wait states except while frozen.
   always_comb begin
      case (i_paddr)
         wdc_pkg::CTRL_ADDR,
         wdc_pkg::UNLOCK_ADDR,
         wdc_pkg::IRQ_STAT_ADDR,
         wdc_pkg::IRQ_EN_ADDR,
         wdc_pkg::IRQ_CLR_ADDR,
         wdc_pkg::COUNT_ADDR: addr_ok = 1'b1;
         default:             addr_ok = 1'b0;
      endcase
   end

   assign o_pready  = i_clk_en;
   assign o_pslverr = i_psel && i_penable && !addr_ok;
   assign wr_acc    = i_psel && i_penable && i_pwrite && i_clk_en;
   assign ctrl_wr   = wr_acc && (i_paddr == wdc_pkg::CTRL_ADDR)
                      && (unl_q == wdc_pkg::UNL_OPEN);

   // Read view of the control register; the clear bit shows a pending clear.
   assign ctrl_rd = {wd_run_q, wd_count_clear_q, wd_timeout_flag_q, wd_lowpower_run_q,
                     wd_reset_cause_flag_q, wd_prescale_select_q};

   wdc_prescaler u_prescaler (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_clk_en  (i_clk_en),
      .i_enable  (count_run),
      .i_restart (wd_count_clear_q || any_reset),
      .i_select  (wd_prescale_select_q),
      .o_tick    (tick)
   );

   // Timed-access sequencer: key one, then key two, opens a short write window.
   always_comb begin
      unl_d = unl_q;
      win_d = win_q;
      case (unl_q)
         wdc_pkg::UNL_LOCKED: begin
            if (wr_acc && i_paddr == wdc_pkg::UNLOCK_ADDR
                && i_pwdata[7:0] == wdc_pkg::UNLOCK_KEY1) begin
               unl_d = wdc_pkg::UNL_ARMED;
            end
         end
         wdc_pkg::UNL_ARMED: begin
            if (wr_acc) begin
               if (i_paddr == wdc_pkg::UNLOCK_ADDR && i_pwdata[7:0] == wdc_pkg::UNLOCK_KEY2) begin
                  unl_d = wdc_pkg::UNL_OPEN;
                  win_d = wdc_pkg::UNLOCK_WIN_CYC;
               end else begin
                  unl_d = wdc_pkg::UNL_LOCKED;
               end
            end
         end
         wdc_pkg::UNL_OPEN: begin
            win_d = win_q - 4'h1;
            if (ctrl_wr || win_q == 4'h1) begin
               unl_d = wdc_pkg::UNL_LOCKED;
               win_d = 4'h0;
            end
         end
         default: begin
            unl_d = wdc_pkg::UNL_LOCKED;
            win_d = 4'h0;
         end
      endcase
      if (any_reset) begin
         unl_d = wdc_pkg::UNL_LOCKED;
         win_d = 4'h0;
      end
   end

   // Control fields: software writes, hardware events, then reset sources.
   always_comb begin
      wd_run_d              = wd_run_q;
      wd_count_clear_d      = 1'b0;
      wd_timeout_flag_d     = wd_timeout_flag_q;
      wd_lowpower_run_d     = wd_lowpower_run_q;
      wd_reset_cause_flag_d = wd_reset_cause_flag_q;
      wd_prescale_select_d  = wd_prescale_select_q;
      if (ctrl_wr) begin
         wd_run_d              = i_pwdata[wdc_pkg::RUN_BIT];
         wd_count_clear_d      = i_pwdata[wdc_pkg::CLR_BIT];
         wd_timeout_flag_d     = i_pwdata[wdc_pkg::TOF_BIT];
         wd_lowpower_run_d     = i_pwdata[wdc_pkg::LPR_BIT];
         wd_reset_cause_flag_d = i_pwdata[wdc_pkg::RCF_BIT];
         wd_prescale_select_d  = i_pwdata[wdc_pkg::PS_MSB:wdc_pkg::PS_LSB];
      end
      // A write while a clear is pending and the counter is stopped takes the written clear bit.
      if (ctrl_wr && wd_count_clear_q && !count_run) begin
         wd_count_clear_d = i_pwdata[wdc_pkg::CLR_BIT];
      end
      if (overflow) begin
         wd_timeout_flag_d = 1'b1;
      end
      if (any_reset) begin
         wd_run_d          = 1'b0;
         wd_count_clear_d  = 1'b0;
         wd_timeout_flag_d = 1'b0;
         wd_lowpower_run_d = 1'b0;
      end
      if (i_wdt_reset) begin
         wd_reset_cause_flag_d = 1'b1;
      end
   end

   // Counter: a pending clear zeroes it, otherwise it advances on each tick.
   always_comb begin
      count_d   = count_q;
      rst_req_d = 1'b0;
      if (wd_count_clear_q || any_reset) begin
         count_d = '0;
      end else if (tick) begin
         count_d = count_q + 1'b1;
         rst_req_d = overflow && !gp_mode;
      end
   end

   // Sticky interrupt status; a new event wins over a clear in the same cycle.
   always_comb begin
      irq_stat_d = irq_stat_q;
      irq_en_d   = irq_en_q;
      if (wr_acc && i_paddr == wdc_pkg::IRQ_CLR_ADDR) begin
         irq_stat_d = irq_stat_q & ~i_pwdata[wdc_pkg::IRQ_W-1:0];
      end
      if (wr_acc && i_paddr == wdc_pkg::IRQ_EN_ADDR) begin
         irq_en_d = i_pwdata[wdc_pkg::IRQ_W-1:0];
      end
      irq_stat_d[wdc_pkg::IRQ_TIMEOUT]  = irq_stat_d[wdc_pkg::IRQ_TIMEOUT] || overflow;
      irq_stat_d[wdc_pkg::IRQ_CLR_DONE] = irq_stat_d[wdc_pkg::IRQ_CLR_DONE] || wd_count_clear_q;
   end

   assign o_irq          = |(irq_stat_q & irq_en_q);
   assign o_wd_reset_req = rst_req_q;

   // Read data is captured in the setup cycle and held through the access.
   always_comb begin
      prdata_d = prdata_q;
      if (i_psel && !i_penable && !i_pwrite) begin
         case (i_paddr)
            wdc_pkg::CTRL_ADDR:     prdata_d = {24'h000000, ctrl_rd};
            wdc_pkg::IRQ_STAT_ADDR: prdata_d = {30'h00000000, irq_stat_q};
            wdc_pkg::IRQ_EN_ADDR:   prdata_d = {30'h00000000, irq_en_q};
            wdc_pkg::COUNT_ADDR:    prdata_d = {26'h0000000, count_q};
            wdc_pkg::UNLOCK_ADDR:   prdata_d = {29'h00000000, unl_q};
            default:                prdata_d = 32'h00000000;
         endcase
      end
   end

   assign o_prdata = prdata_q;

   // State registers; the synchronous reset is the power-on reset.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         wd_run_q              <= 1'b0;
         wd_count_clear_q      <= 1'b0;
         wd_timeout_flag_q     <= 1'b0;
         wd_lowpower_run_q     <= 1'b0;
         wd_reset_cause_flag_q <= 1'b0;
         wd_prescale_select_q  <= wdc_pkg::PS_POR;
         count_q               <= '0;
         unl_q                 <= wdc_pkg::UNL_LOCKED;
         win_q                 <= 4'h0;
         irq_stat_q            <= '0;
         irq_en_q              <= wdc_pkg::IRQ_EN_RST;
         prdata_q              <= 32'h00000000;
         rst_req_q             <= 1'b0;
      end else if (i_clk_en) begin
         wd_run_q              <= wd_run_d;
         wd_count_clear_q      <= wd_count_clear_d;
         wd_timeout_flag_q     <= wd_timeout_flag_d;
         wd_lowpower_run_q     <= wd_lowpower_run_d;
         wd_reset_cause_flag_q <= wd_reset_cause_flag_d;
         wd_prescale_select_q  <= wd_prescale_select_d;
         count_q               <= count_d;
         unl_q                 <= unl_d;
         win_q                 <= win_d;
         irq_stat_q            <= irq_stat_d;
         irq_en_q              <= irq_en_d;
         prdata_q              <= prdata_d;
         rst_req_q             <= rst_req_d;
      end
   end

endmodule : wdc_watchdog_control

/* bench/wdc_props.sv */
module wdc_props (
   input wire logic        i_ref_clk,
   input wire logic        i_reset,
   input wire logic        i_clk_en,
   input wire logic        i_wdt_reset,
   input wire logic [3:0]  i_nv_enable_field,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pslverr,
   input wire logic        o_irq,
   input wire logic        o_wd_reset_req
);
   timeunit 1ns;
   timeprecision 1ns;
   logic acc, map, rdc, wdr_d, wdr_q;

   // Access phases and the decoded register map.
   assign acc = i_psel && i_penable && i_clk_en;
   assign rdc = acc && !i_pwrite && i_paddr == wdc_pkg::CTRL_ADDR;
   assign map = i_paddr inside {wdc_pkg::CTRL_ADDR, wdc_pkg::UNLOCK_ADDR, wdc_pkg::COUNT_ADDR,
      wdc_pkg::IRQ_STAT_ADDR, wdc_pkg::IRQ_EN_ADDR, wdc_pkg::IRQ_CLR_ADDR};

   // Remembers a watchdog reset until software next writes the control register.
   always_comb begin
      wdr_d = wdr_q;
      if (i_clk_en && i_wdt_reset) wdr_d = 1'b1;
      else if (acc && i_pwrite && i_paddr == wdc_pkg::CTRL_ADDR) wdr_d = 1'b0;
   end

   // Registers the watchdog reset memory.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) wdr_q <= 1'b0;
      else wdr_q <= wdr_d;
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   chk_error_decode : assert property (
      o_pslverr == (i_psel && i_penable && !map))
      else $error("slave error does not follow the address decode");
   chk_unmapped_zero : assert property (
      i_psel && i_penable && !i_pwrite && !map |-> o_prdata == 32'h0)
      else $error("unmapped read returned nonzero data");
   chk_mask_drops_irq : assert property (
      acc && i_pwrite && i_paddr == wdc_pkg::IRQ_EN_ADDR && i_pwdata[1:0] == 2'h0 |=> !o_irq)
      else $error("interrupt stayed high with every enable cleared");
   chk_reset_quiet : assert property (disable iff (1'b0)
      i_reset && i_clk_en |=> !o_irq && !o_wd_reset_req)
      else $error("outputs active after power-on reset");
   chk_req_one_cycle : assert property (
      o_wd_reset_req |=> !o_wd_reset_req)
      else $error("chip reset request longer than one cycle");
   chk_req_wd_mode : assert property (
      o_wd_reset_req |-> $past(i_nv_enable_field) != wdc_pkg::NV_GP_TIMER)
      else $error("chip reset request in general-purpose timer use");
   chk_cause_flag_set : assert property (
      rdc && wdr_q && $past(wdr_q) |-> o_prdata[wdc_pkg::RCF_BIT])
      else $error("reset cause flag clear after a watchdog reset");
   chk_ctrl_upper_zero : assert property (
      rdc |-> o_prdata[31:8] == 24'h0)
      else $error("control read has nonzero upper bits");

   cover property (o_wd_reset_req);
   cover property (acc && o_pslverr);
   cover property (rdc && wdr_q);
endmodule : wdc_props

bind wdc_watchdog_control wdc_props chk_u (.*);

/* bench/wdc_watchdog_control_test.sv */
module wdc_watchdog_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_ref_clk, i_reset, i_clk_en, i_wdt_reset, i_other_reset, i_lowpower;
   logic        i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq, o_wd_reset_req, er;
   logic [3:0]  i_nv_enable_field;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rv;
   int          err_count, compares, dl, n;
   int          ratio [8] = '{1, 4, 8, 16, 32, 64, 128, 256};

   wdc_watchdog_control dut_u (.*);

   // Reference clock.
   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end

   // Counts a comparison and reports a mismatch.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer and an idle cycle; read data lands in rv, the error in er.
   // The wait for ready has no limit of its own; the watchdog ends a hang.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      @(posedge i_ref_clk);
      while (o_pready !== 1'b1) begin
         @(posedge i_ref_clk);
      end
      rv = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_ref_clk);
   endtask : xfer

   task automatic rd(input logic [11:0] a);
      xfer(1'b0, a, 32'h0);
   endtask : rd

   // Timed-access unlock, then optionally one control write.
   task automatic ul();
      xfer(1'b1, wdc_pkg::UNLOCK_ADDR, {24'h0, wdc_pkg::UNLOCK_KEY1});
      xfer(1'b1, wdc_pkg::UNLOCK_ADDR, {24'h0, wdc_pkg::UNLOCK_KEY2});
   endtask : ul

   task automatic wctl(input logic [7:0] d);
      ul();
      xfer(1'b1, wdc_pkg::CTRL_ADDR, {24'h0, d});
   endtask : wctl

   // Counter advance between two counter samples s cycles apart.
   task automatic delta(input int s);
      logic [31:0] c;
      rd(wdc_pkg::COUNT_ADDR);
      c = rv;
      repeat (s - 3) @(posedge i_ref_clk);
      rd(wdc_pkg::COUNT_ADDR);
      dl = int'((rv - c) & ((32'h1 << wdc_pkg::COUNT_W) - 32'h1));
   endtask : delta

   task automatic summarize();
      if (err_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   // Limit well above the few thousand cycles the sequence needs.
   initial begin
      #400000;
      err_count++;
      summarize();
   end

   // Main sequence.
   initial begin
      i_reset = 1'b1;
      i_clk_en = 1'b1;
      i_wdt_reset = 1'b0;
      i_other_reset = 1'b0;
      i_lowpower = 1'b0;
      i_nv_enable_field = wdc_pkg::NV_GP_TIMER;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 12'h0;
      i_pwdata = 32'h0;
      repeat (10) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, {29'h0, wdc_pkg::PS_POR});
      rd(wdc_pkg::COUNT_ADDR);
      chk(rv, 32'h0);
      xfer(1'b1, wdc_pkg::CTRL_ADDR, 32'h80);
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, 32'h07);
      ul();
      rd(wdc_pkg::UNLOCK_ADDR);
      chk(rv, 32'(wdc_pkg::UNL_OPEN));
      repeat (10) @(posedge i_ref_clk);
      xfer(1'b1, wdc_pkg::CTRL_ADDR, 32'h80);
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, 32'h07);
      // Every prescale code gives about four counts per ratio times four cycles.
      for (int k = 0; k < 8; k++) begin
         wctl(8'h80 | k[7:0]);
         delta(ratio[k] * 4);
         chk(dl inside {[3:5]}, 1'b1);
      end
      // Clear while stopped: the count is zero and stays there.
      wctl(8'h40);
      rd(wdc_pkg::COUNT_ADDR);
      chk(rv, 32'h0);
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, 32'h0);
      rd(wdc_pkg::IRQ_STAT_ADDR);
      chk(rv, 32'h2);
      delta(20);
      chk(dl, 0);
      // Overflow raises the flag and interrupt; mask, unmask and clear it.
      xfer(1'b1, wdc_pkg::IRQ_CLR_ADDR, 32'h3);
      xfer(1'b1, wdc_pkg::IRQ_EN_ADDR, 32'h1);
      chk(o_irq, 1'b0);
      wctl(8'h80);
      repeat (70) @(posedge i_ref_clk);
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, 32'ha0);
      chk(o_irq, 1'b1);
      wctl(8'h00);
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, 32'h0);
      xfer(1'b1, wdc_pkg::IRQ_EN_ADDR, 32'h0);
      chk(o_irq, 1'b0);
      xfer(1'b1, wdc_pkg::IRQ_EN_ADDR, 32'h1);
      chk(o_irq, 1'b1);
      xfer(1'b1, wdc_pkg::IRQ_CLR_ADDR, 32'h1);
      chk(o_irq, 1'b0);
      rd(wdc_pkg::IRQ_STAT_ADDR);
      chk(rv, 32'h0);
      // Low-power mode halts the timer unless the low-power run bit is set.
      i_lowpower <= 1'b1;
      wctl(8'h80);
      delta(8);
      chk(dl, 0);
      wctl(8'h90);
      delta(8);
      chk(dl, 8);
      // A low clock enable drops ready and freezes the running counter.
      rd(wdc_pkg::COUNT_ADDR);
      n = int'(rv);
      i_clk_en <= 1'b0;
      repeat (20) @(posedge i_ref_clk);
      chk(o_pready, 1'b0);
      i_clk_en <= 1'b1;
      rd(wdc_pkg::COUNT_ADDR);
      chk(rv, 32'((n + 3) % (1 << wdc_pkg::COUNT_W)));
      i_lowpower <= 1'b0;
      // Watchdog use: overflow requests a chip reset; reset sources treat flags apart.
      i_nv_enable_field <= 4'h0;
      wctl(8'h02);
      n = 0;
      while (o_wd_reset_req !== 1'b1 && n < 2000) begin
         @(posedge i_ref_clk);
         n++;
      end
      chk(n < 2000, 1'b1);
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, 32'h22);
      i_wdt_reset <= 1'b1;
      @(posedge i_ref_clk);
      i_wdt_reset <= 1'b0;
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, 32'h0a);
      wctl(8'hfa);
      i_other_reset <= 1'b1;
      @(posedge i_ref_clk);
      i_other_reset <= 1'b0;
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, 32'h0a);
      i_reset <= 1'b1;
      @(posedge i_ref_clk);
      i_reset <= 1'b0;
      rd(wdc_pkg::CTRL_ADDR);
      chk(rv, 32'h07);
      // Unmapped address answers with an error and reads zero.
      xfer(1'b1, 12'h004, 32'hff);
      chk(er, 1'b1);
      rd(12'h004);
      chk(rv, 32'h0);
      summarize();
   end
endmodule : wdc_watchdog_control_test
